// File: inc/arcf_pkg.sv
// Constants, field layouts and payload types of the read channel FIFO pair
package arcf_pkg;

    // FIFO geometry
    localparam int FIFO_DEPTH = 16;           // Entries per FIFO
    localparam int PTR_W      = 4;            // log2 of depth
    localparam int CNT_W      = PTR_W + 1;    // Word count width
    localparam int THR_W      = PTR_W;        // Threshold width

    // AXI field widths
    localparam bit AXI4_MODE = 1'b1;          // 1 selects AXI4, 0 AXI3
    localparam int ID_W      = 4;             // Transaction ID width
    localparam int ADDR_W    = 32;            // Address width
    localparam int DATA_W    = 32;            // One of 8,16,...,512
    localparam int USER_W    = 1;             // User sideband width
    localparam int LEN_W     = AXI4_MODE ? 8 : 4;   // Burst length width
    localparam int LOCK_W    = AXI4_MODE ? 1 : 2;   // Lock type width

    // Read response codes, carried untouched
    typedef enum logic [1:0] {
        RESP_OKAY,
        RESP_EXOKAY,
        RESP_SLVERR,
        RESP_DECERR
    } arcf_resp_t;

    // Read address payload
    typedef struct packed {
        logic [ID_W-1:0]   id;               // Transaction ID
        logic [ADDR_W-1:0] addr;             // Start address
        logic [LEN_W-1:0]  len;              // Beats minus one
        logic [2:0]        size;             // Beat size
        logic [1:0]        burst;            // Burst type
        logic [LOCK_W-1:0] lock;             // Lock type
        logic [3:0]        cache;            // Cache attributes
        logic [2:0]        prot;             // Protection
        logic [3:0]        qos;              // Quality of service
        logic [3:0]        region;           // Region (unused on AXI3)
        logic [USER_W-1:0] user;             // User sideband
    } arcf_ar_t;

    // Read data payload
    typedef struct packed {
        logic [ID_W-1:0]   id;               // Matches request ID
        logic [DATA_W-1:0] data;             // Read data
        arcf_resp_t        resp;             // Response code
        logic              last;             // Final beat of burst
        logic [USER_W-1:0] user;             // User sideband
    } arcf_r_t;

    localparam int AR_W = $bits(arcf_ar_t);  // Packed address word
    localparam int R_W  = $bits(arcf_r_t);   // Packed data word

    // Register map (byte addresses)
    localparam int         WB_ADR_W  = 4;
    localparam logic [3:0] REG_AR_THR  = 4'h0;  // Address FIFO thresholds
    localparam logic [3:0] REG_R_THR   = 4'h4;  // Data FIFO thresholds
    localparam logic [3:0] REG_AR_STAT = 4'h8;  // Address FIFO status
    localparam logic [3:0] REG_R_STAT  = 4'hC;  // Data FIFO status

    // Threshold register layout
    localparam int THR_HIGH_LSB = 0;
    localparam int THR_LOW_LSB  = 8;
    localparam int THR_HIGH_SEL = 0;          // Byte lane of high field
    localparam int THR_LOW_SEL  = 1;          // Byte lane of low field
    localparam logic [THR_W-1:0] HIGH_THR_RST = 4'hE;
    localparam logic [THR_W-1:0] LOW_THR_RST  = 4'h2;

    // Status register layout
    localparam int STAT_STORED_LSB   = 0;
    localparam int STAT_READABLE_LSB = 8;
    localparam int STAT_HIGH_BIT     = 16;
    localparam int STAT_LOW_BIT      = 17;
    localparam int STAT_REFUSED_BIT  = 18;

endpackage : arcf_pkg

// File: design/arcf_top.sv
// Read address and read data FIFO pair with a Wishbone status port
//
// Our own choices: the Wishbone register port and the address map.

// Synchronous FIFO with registered head, counts and threshold flags
module arcf_fifo #(
    parameter int WIDTH = 8                       // Word width
) (
    input  wire logic                        clk,          // Clock
    input  wire logic                        rst,          // Async reset
    input  wire logic                        ce,           // Clock enable
    input  wire logic                        inValid,      // Write offer
    input  wire logic [WIDTH-1:0]            inData,       // Write word
    output logic                             inReady,      // Space left
    output logic                             outValid,     // Head valid
    output logic [WIDTH-1:0]                 outData,      // Head word
    input  wire logic                        outReady,     // Head taken
    input  wire logic [arcf_pkg::THR_W-1:0]  highThr,      // High level
    input  wire logic [arcf_pkg::THR_W-1:0]  lowThr,       // Low level
    output logic [arcf_pkg::CNT_W-1:0]       storedWords,  // Word count
    output logic [arcf_pkg::CNT_W-1:0]       readableWords,// Readable
    output logic                             almostHigh,   // High flag
    output logic                             almostLow,    // Low flag
    output logic                             readRefused   // Empty read
);

    logic [WIDTH-1:0]                mem_q [arcf_pkg::FIFO_DEPTH]; // Store
    logic [arcf_pkg::PTR_W-1:0]      wrPtr_q;     // Next slot to fill
    logic [arcf_pkg::PTR_W-1:0]      rdPtr_q;     // Current head slot
    logic [arcf_pkg::PTR_W-1:0]      rdPtr_d;     // Head slot after edge
    logic [arcf_pkg::CNT_W-1:0]      count_q;     // Words held
    logic [arcf_pkg::CNT_W-1:0]      count_d;     // Words after edge
    logic [WIDTH-1:0]                head_d;      // Head word after edge
    logic                            inReady_q;   // Registered space flag
    logic                            outValid_q;  // Registered head flag
    logic [WIDTH-1:0]                outData_q;   // Registered head word
    logic                            almostHigh_q;// High flag register
    logic                            almostLow_q; // Low flag register
    logic                            refused_q;   // Empty read flag
    logic                            wrEn;        // Beat written
    logic                            rdEn;        // Beat removed

    // Handshakes; ready and valid come from flops so no comb path crosses
    assign wrEn = inValid & inReady_q;
    assign rdEn = outValid_q & outReady;

    // Next head pointer and occupancy
    always_comb begin
        rdPtr_d = rdPtr_q + arcf_pkg::PTR_W'(rdEn);
        unique case ({wrEn, rdEn})
            2'b10:   count_d = count_q + 1'b1;
            2'b01:   count_d = count_q - 1'b1;
            default: count_d = count_q;
        endcase
    end

    // Next head word; bypass when the new head is being written now
    always_comb begin
        if (wrEn && (wrPtr_q == rdPtr_d)) begin
            head_d = inData;
        end else begin
            head_d = mem_q[rdPtr_d];
        end
    end

    // Storage, one slot per entry; no reset needed for data
    for (genvar i = 0; i < arcf_pkg::FIFO_DEPTH; i++) begin : gSlot
        always_ff @(posedge clk) begin
            if (ce && wrEn && (wrPtr_q == arcf_pkg::PTR_W'(i))) begin
                mem_q[i] <= inData;
            end
        end
    end

    // Pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (ce) begin
            wrPtr_q <= wrPtr_q + arcf_pkg::PTR_W'(wrEn);
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // Handshake side of both ports
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inReady_q  <= 1'b0;
            outValid_q <= 1'b0;
            outData_q  <= '0;
        end else if (ce) begin
            // Full check on the next count keeps a full FIFO closed
            inReady_q  <= (count_d
                < arcf_pkg::CNT_W'(arcf_pkg::FIFO_DEPTH));
            outValid_q <= (count_d != '0);
            outData_q  <= head_d;
        end
    end

    // Threshold flags; thresholds are zero-extended to count width
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            almostHigh_q <= 1'b0;
            almostLow_q  <= 1'b1;
        end else if (ce) begin
            almostHigh_q <= (count_d >= {1'b0, highThr});
            almostLow_q  <= (count_d <= {1'b0, lowThr});
        end
    end

    // Empty read: ready offered while nothing was presented
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (ce) begin
            refused_q <= outReady & ~outValid_q;
        end
    end

    assign inReady       = inReady_q;
    assign outValid      = outValid_q;
    assign outData       = outData_q;
    assign storedWords   = count_q;
    // Write reaches the head on the same edge as the count, so it never over-reports
    assign readableWords = count_q;
    assign almostHigh    = almostHigh_q;
    assign almostLow     = almostLow_q;
    assign readRefused   = refused_q;

endmodule // arcf_fifo

// Top: address FIFO toward slave, data FIFO toward master, register port
module arcf_top (
    input  wire logic                          clk,        // 125 MHz clock
    input  wire logic                          rst,        // Async reset
    input  wire logic                          ce,         // Clock enable
    // Wishbone classic slave
    input  wire logic                          wbCyc,      // Cycle
    input  wire logic                          wbStb,      // Strobe
    input  wire logic                          wbWe,       // Write
    input  wire logic [arcf_pkg::WB_ADR_W-1:0] wbAdr,      // Byte address
    input  wire logic [3:0]                    wbSel,      // Byte lanes
    input  wire logic [31:0]                   wbDatW,     // Write data
    output logic [31:0]                        wbDatR,     // Read data
    output logic                               wbAck,      // Acknowledge
    // Read address from the upstream master
    input  wire logic                          sArValid,   // Address valid
    input  wire arcf_pkg::arcf_ar_t            sArPayload, // Address fields
    output logic                               sArReady,   // Address ready
    // Read address to the downstream slave
    output logic                               mArValid,   // Address valid
    output arcf_pkg::arcf_ar_t                 mArPayload, // Address fields
    input  wire logic                          mArReady,   // Address ready
    // Read data from the downstream slave
    input  wire logic                          mRValid,    // Beat valid
    input  wire arcf_pkg::arcf_r_t             mRPayload,  // Beat fields
    output logic                               mRReady,    // Beat ready
    // Read data to the upstream master
    output logic                               sRValid,    // Beat valid
    output arcf_pkg::arcf_r_t                  sRPayload,  // Beat fields
    input  wire logic                          sRReady,    // Beat ready
    // Address FIFO sideband
    output logic                               addrFifoReadRefusedFlag,
    output logic [arcf_pkg::CNT_W-1:0]         addrFifoReadableWords,
    output logic [arcf_pkg::CNT_W-1:0]         addrFifoStoredWords,
    output logic                               addrFifoAlmostHighFlag,
    output logic                               addrFifoAlmostLowFlag
);

    logic [arcf_pkg::THR_W-1:0] addrFifoHighThreshold_q; // Address high
    logic [arcf_pkg::THR_W-1:0] addrFifoLowThreshold_q;  // Address low
    logic [arcf_pkg::THR_W-1:0] rHighThr_q;              // Data high
    logic [arcf_pkg::THR_W-1:0] rLowThr_q;               // Data low
    logic [arcf_pkg::AR_W-1:0]  arOut;                   // Address head
    logic [arcf_pkg::R_W-1:0]   rOut;                    // Data head
    logic [arcf_pkg::CNT_W-1:0] rStored;                 // Data count
    logic [arcf_pkg::CNT_W-1:0] rReadable;               // Data readable
    logic                       rHigh;                   // Data high flag
    logic                       rLow;                    // Data low flag
    logic                       rRefused;                // Data empty read
    logic                       wbAck_q;                 // Ack register
    logic [31:0]                wbDatR_q;                // Read data reg
    logic                       wbReq;                   // New access
    logic [31:0]                rdMux;                   // Decoded read

    // Address FIFO: whole request word, including width-selected fields
    arcf_fifo #(
        .WIDTH (arcf_pkg::AR_W)
    ) uArFifo (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .inValid       (sArValid),
        .inData        (sArPayload),
        .inReady       (sArReady),
        .outValid      (mArValid),
        .outData       (arOut),
        .outReady      (mArReady),
        .highThr       (addrFifoHighThreshold_q),
        .lowThr        (addrFifoLowThreshold_q),
        .storedWords   (addrFifoStoredWords),
        .readableWords (addrFifoReadableWords),
        .almostHigh    (addrFifoAlmostHighFlag),
        .almostLow     (addrFifoAlmostLowFlag),
        .readRefused   (addrFifoReadRefusedFlag)
    );

    assign mArPayload = arcf_pkg::arcf_ar_t'(arOut);

    // Data FIFO: ID, data, response, last and user travel as one word
    arcf_fifo #(
        .WIDTH (arcf_pkg::R_W)
    ) uRFifo (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .inValid       (mRValid),
        .inData        (mRPayload),
        .inReady       (mRReady),
        .outValid      (sRValid),
        .outData       (rOut),
        .outReady      (sRReady),
        .highThr       (rHighThr_q),
        .lowThr        (rLowThr_q),
        .storedWords   (rStored),
        .readableWords (rReadable),
        .almostHigh    (rHigh),
        .almostLow     (rLow),
        .readRefused   (rRefused)
    );

    // Response, last and data width are untouched by the word cast
    assign sRPayload = arcf_pkg::arcf_r_t'(rOut);

    // One access per ack; the gap after ack stops a double write
    assign wbReq = wbCyc & wbStb & ~wbAck_q;

    // Threshold registers; meant to be set while the FIFOs are idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrFifoHighThreshold_q <= arcf_pkg::HIGH_THR_RST;
            addrFifoLowThreshold_q  <= arcf_pkg::LOW_THR_RST;
            rHighThr_q              <= arcf_pkg::HIGH_THR_RST;
            rLowThr_q               <= arcf_pkg::LOW_THR_RST;
        end else if (ce && wbReq && wbWe) begin
            if (wbAdr == arcf_pkg::REG_AR_THR) begin
                if (wbSel[arcf_pkg::THR_HIGH_SEL]) begin
                    addrFifoHighThreshold_q <= wbDatW[arcf_pkg::THR_HIGH_LSB
                        +: arcf_pkg::THR_W];
                end
                if (wbSel[arcf_pkg::THR_LOW_SEL]) begin
                    addrFifoLowThreshold_q <= wbDatW[arcf_pkg::THR_LOW_LSB
                        +: arcf_pkg::THR_W];
                end
            end
            if (wbAdr == arcf_pkg::REG_R_THR) begin
                if (wbSel[arcf_pkg::THR_HIGH_SEL]) begin
                    rHighThr_q <= wbDatW[arcf_pkg::THR_HIGH_LSB
                        +: arcf_pkg::THR_W];
                end
                if (wbSel[arcf_pkg::THR_LOW_SEL]) begin
                    rLowThr_q <= wbDatW[arcf_pkg::THR_LOW_LSB
                        +: arcf_pkg::THR_W];
                end
            end
        end
    end

    // Read decode; unmapped addresses read zero and still ack
    always_comb begin
        rdMux = '0;
        case (wbAdr)
            arcf_pkg::REG_AR_THR: begin
                rdMux[arcf_pkg::THR_HIGH_LSB +: arcf_pkg::THR_W] =
                    addrFifoHighThreshold_q;
                rdMux[arcf_pkg::THR_LOW_LSB +: arcf_pkg::THR_W] =
                    addrFifoLowThreshold_q;
            end
            arcf_pkg::REG_R_THR: begin
                rdMux[arcf_pkg::THR_HIGH_LSB +: arcf_pkg::THR_W] = rHighThr_q;
                rdMux[arcf_pkg::THR_LOW_LSB +: arcf_pkg::THR_W]  = rLowThr_q;
            end
            arcf_pkg::REG_AR_STAT: begin
                rdMux[arcf_pkg::STAT_STORED_LSB +: arcf_pkg::CNT_W] =
                    addrFifoStoredWords;
                rdMux[arcf_pkg::STAT_READABLE_LSB +: arcf_pkg::CNT_W] =
                    addrFifoReadableWords;
                rdMux[arcf_pkg::STAT_HIGH_BIT]    = addrFifoAlmostHighFlag;
                rdMux[arcf_pkg::STAT_LOW_BIT]     = addrFifoAlmostLowFlag;
                rdMux[arcf_pkg::STAT_REFUSED_BIT] = addrFifoReadRefusedFlag;
            end
            arcf_pkg::REG_R_STAT: begin
                rdMux[arcf_pkg::STAT_STORED_LSB +: arcf_pkg::CNT_W] = rStored;
                rdMux[arcf_pkg::STAT_READABLE_LSB +: arcf_pkg::CNT_W] =
                    rReadable;
                rdMux[arcf_pkg::STAT_HIGH_BIT]    = rHigh;
                rdMux[arcf_pkg::STAT_LOW_BIT]     = rLow;
                rdMux[arcf_pkg::STAT_REFUSED_BIT] = rRefused;
            end
            default: rdMux = '0;                      // Unmapped
        endcase
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wbAck_q  <= 1'b0;
            wbDatR_q <= '0;
        end else if (ce) begin
            wbAck_q  <= wbReq;
            wbDatR_q <= (wbReq && !wbWe) ? rdMux : 32'h0000_0000;
        end
    end

    assign wbAck  = wbAck_q;
    assign wbDatR = wbDatR_q;

endmodule // arcf_top

// File: verification/arcf_top_sva.sv
// Port-level assertions for the read channel FIFO pair
module arcf_top_sva (
    input wire logic                         clk,          // Clock
    input wire logic                         rst,          // Async reset
    input wire logic                         ce,           // Clock enable
    input wire logic                         wbCyc,        // Bus cycle
    input wire logic                         wbStb,        // Bus strobe
    input wire logic                         wbAck,        // Bus ack
    input wire logic                         sArValid,     // AR offer
    input wire logic                         sArReady,     // AR space
    input wire logic                         mArValid,     // AR head
    input wire logic                         mArReady,     // AR taken
    input wire logic                         sRValid,      // R head
    input wire logic                         sRReady,      // R taken
    input wire arcf_pkg::arcf_r_t            sRPayload,    // R fields
    input wire logic                         addrFifoReadRefusedFlag,
    input wire logic [arcf_pkg::CNT_W-1:0]   addrFifoReadableWords,
    input wire logic [arcf_pkg::CNT_W-1:0]   addrFifoStoredWords,
    input wire logic                         addrFifoAlmostHighFlag,
    input wire logic                         addrFifoAlmostLowFlag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Ready offered on an empty head flags exactly one cycle later
    refused_flag_a: assert property (ce && mArReady && !mArValid |=>
        addrFifoReadRefusedFlag) else $error("refused flag missing");
    // A refused read leaves the count alone
    refused_keeps_a: assert property (ce && mArReady && !mArValid
        && !(sArValid && sArReady) |=> $stable(addrFifoStoredWords))
        else $error("refused read changed count");
    // A pure read lowers the count by one on the next edge
    read_count_a: assert property (ce && mArValid && mArReady
        && !(sArValid && sArReady) |=> addrFifoStoredWords ==
        $past(addrFifoStoredWords) - 5'h01) else $error("count not down");
    readable_le_a: assert property (addrFifoReadableWords <=
        addrFifoStoredWords) else $error("readable over-reports");
    full_flags_a: assert property (addrFifoStoredWords == 5'h10
        |-> addrFifoAlmostHighFlag && !addrFifoAlmostLowFlag && !sArReady)
        else $error("full state flags wrong");
    empty_low_a: assert property (addrFifoStoredWords == 5'h00 |->
        addrFifoAlmostLowFlag && !mArValid) else $error("empty flags wrong");
    head_valid_a: assert property (addrFifoStoredWords != 5'h00 |->
        mArValid) else $error("head valid missing");
    // Presented beat holds until taken
    beat_hold_a: assert property (ce && sRValid && !sRReady |=>
        sRValid && $stable(sRPayload)) else $error("beat dropped");
    bus_ack_a: assert property (ce && wbCyc && wbStb && !wbAck |=>
        wbAck ##1 !wbAck) else $error("bus ack timing wrong");
    // Main scenarios
    refused_c: cover property (addrFifoReadRefusedFlag);
    full_c: cover property (addrFifoStoredWords == 5'h10);
    last_c: cover property (sRValid && sRReady && sRPayload.last);
endmodule // arcf_top_sva

bind arcf_top arcf_top_sva u_sva (.clk, .rst, .ce, .wbCyc, .wbStb, .wbAck,
    .sArValid, .sArReady, .mArValid, .mArReady, .sRValid, .sRReady,
    .sRPayload, .addrFifoReadRefusedFlag, .addrFifoReadableWords,
    .addrFifoStoredWords, .addrFifoAlmostHighFlag, .addrFifoAlmostLowFlag);

// File: verification/arcf_slave_model.sv
// Downstream slave model: takes addresses, returns bursts of beats
module arcf_slave_model (
    input  wire logic               clk,        // Clock
    input  wire logic               rst,        // Async reset
    input  wire logic               hold,       // Refuse addresses
    input  wire logic               slow,       // Act every other cycle
    input  wire logic               mArValid,   // Address valid
    input  wire arcf_pkg::arcf_ar_t mArPayload, // Address fields
    output logic                    mArReady,   // Address ready
    output logic                    mRValid,    // Beat valid
    output arcf_pkg::arcf_r_t       mRPayload,  // Beat fields
    input  wire logic               mRReady     // Beat ready
);
    timeunit 1ns;
    timeprecision 1ps;
    arcf_pkg::arcf_ar_t pend[$];                // Accepted requests
    logic [7:0]         beat;                   // Beat within burst
    logic               tick;                   // Half-rate phase
    // One process: queue order must match handshake order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {mArReady, mRValid, beat, tick} <= '0;
            mRPayload <= '0;
        end else begin
            tick <= ~tick;
            mArReady <= !hold && (!slow || tick);
            if (mArValid && mArReady)
                pend.push_back(mArPayload);
            if (mRValid && mRReady) begin
                // Released beat lines show garbage, not the old beat
                mRValid <= 1'b0;
                mRPayload <= ~mRPayload;
                beat <= mRPayload.last ? 8'h00 : beat + 8'h01;
                if (mRPayload.last)
                    void'(pend.pop_front());
            end else if (!mRValid && pend.size() != 0 && (!slow || tick)) begin
                mRValid <= 1'b1;
                mRPayload.id <= pend[0].id;
                mRPayload.data <= {pend[0].addr[23:0], beat};
                mRPayload.resp <= arcf_pkg::arcf_resp_t'(pend[0].addr[5:4]);
                mRPayload.last <= beat == pend[0].len;
                mRPayload.user <= beat[0];
            end
        end
    end
endmodule // arcf_slave_model

// File: verification/arcf_top_test.sv
// Self-checking bench for the read channel FIFO pair
module arcf_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wbCyc, wbStb, wbWe, wbAck, hold, slow;
    logic [3:0] wbAdr, wbSel;
    logic [31:0] wbDatW, wbDatR, rd;
    logic sArValid, sArReady, mArValid, mArReady, mRValid, mRReady;
    logic sRValid, sRReady, rfl, hif, lof;
    logic [4:0] rdw, stw;
    arcf_pkg::arcf_ar_t sArPayload, mArPayload;
    arcf_pkg::arcf_r_t  mRPayload, sRPayload;
    int error_cnt = 0, tests_run = 0;
    arcf_top u_dut (.clk, .rst, .ce(1'b1), .wbCyc, .wbStb, .wbWe, .wbAdr,
        .wbSel, .wbDatW, .wbDatR, .wbAck, .sArValid, .sArPayload, .sArReady,
        .mArValid, .mArPayload, .mArReady, .mRValid, .mRPayload, .mRReady,
        .sRValid, .sRPayload, .sRReady, .addrFifoReadRefusedFlag(rfl),
        .addrFifoReadableWords(rdw), .addrFifoStoredWords(stw),
        .addrFifoAlmostHighFlag(hif), .addrFifoAlmostLowFlag(lof));
    arcf_slave_model u_slv (.clk, .rst, .hold, .slow, .mArValid, .mArPayload,
        .mArReady, .mRValid, .mRPayload, .mRReady);
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_beat(input arcf_pkg::arcf_r_t e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] beat exp %h got %h", e, g);
        end
    endtask
    // Classic single cycle; waits for ack, then releases
    task automatic wb(input logic we, input logic [3:0] a, s,
                      input logic [31:0] w);
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'b11, we, a, s, w};
        do @(posedge clk); while (wbAck !== 1'b1);
        rd = wbDatR;
        {wbCyc, wbStb, wbWe} <= 3'b000;
        @(posedge clk);
    endtask
    // Expected status word with thresholds high 3, low 1
    function automatic logic [31:0] st(input int n, input logic r);
        return {13'h0, r, n <= 1, n >= 3, 3'h0, n[4:0], 3'h0, n[4:0]};
    endfunction
    task automatic ar_send(input int i, input logic [7:0] len);
        arcf_pkg::arcf_ar_t p;
        p = '0;
        p.id = i[3:0];
        p.addr = 32'(i) << 4;
        p.len = len;
        sArValid <= 1'b1;
        sArPayload <= p;
        do @(posedge clk); while (sArReady !== 1'b1);
        sArValid <= 1'b0;
        sArPayload <= ~p;
    endtask
    task automatic r_take(input int i, input logic [7:0] b, len);
        arcf_pkg::arcf_r_t e;
        logic [31:0] a;
        a = 32'(i) << 4;
        e = {i[3:0], a[23:0], b, arcf_pkg::arcf_resp_t'(a[5:4]), b == len,
             b[0]};
        do @(posedge clk); while (sRValid !== 1'b1);
        chk_beat(e, sRPayload);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        {rst, wbWe, wbAdr, wbSel, wbDatW} = '1;
        {wbCyc, wbStb, sArValid, sRReady, hold, slow} = '0;
        sArPayload = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        wb(0, arcf_pkg::REG_AR_THR, 4'hF, 0);
        chk("thr reset", 32'h0000_020E, rd);
        wb(0, arcf_pkg::REG_AR_STAT, 4'hF, 0);
        chk("idle stat", 32'h0006_0000, rd);
        wb(1, arcf_pkg::REG_AR_THR, 4'h3, 32'h0000_0103);
        wb(1, arcf_pkg::REG_AR_THR, 4'h1, 32'h0000_0F05);
        wb(0, arcf_pkg::REG_AR_THR, 4'hF, 0);
        chk("thr sel", 32'h0000_0105, rd);
        wb(1, arcf_pkg::REG_AR_THR, 4'h1, 32'h0000_0003);
        // Stop the slave early so no ready-on-empty leaks into the fill
        hold <= 1'b1;
        wb(0, 4'h2, 4'hF, 0);
        chk("unmapped", 32'h0, rd);
        for (int i = 1; i <= 16; i++) begin
            ar_send(i, 8'h00);
            wb(0, arcf_pkg::REG_AR_STAT, 4'hF, 0);
            chk("fill stat", st(i, 1'b0), rd);
        end
        chk("full ready", 32'h0, 32'(sArReady));
        hold <= 1'b0;
        for (int k = 0; k < 200 && mRReady !== 1'b0; k++)
            @(posedge clk);
        ar_send(10, 8'h03);
        repeat (8) @(posedge clk);
        chk("r full", 32'h0, 32'(mRReady));
        wb(0, arcf_pkg::REG_R_STAT, 4'hF, 0);
        chk("r stat", 32'h0001_1010, rd);
        wb(0, arcf_pkg::REG_AR_STAT, 4'hF, 0);
        chk("drained", st(0, 1'b1), rd);
        slow <= 1'b1;
        sRReady <= 1'b1;
        for (int i = 1; i <= 16; i++)
            r_take(i, 8'h00, 8'h00);
        for (int b = 0; b < 4; b++)
            r_take(10, 8'(b), 8'h03);
        sRReady <= 1'b0;
        repeat (4) @(posedge clk);
        chk("r empty", 32'h0, 32'(sRValid));
        end_sim();
    end
endmodule // arcf_top_test
